/* core/ffc_readout_consts.vh */
// timing and geometry constants for the full frame readout controller
`ifndef FFC_READOUT_CONSTS_VH
`define FFC_READOUT_CONSTS_VH
// clock rate in MHz (20 MHz, 50 ns period)
`define FFC_CLK_MHZ 20
// minimum vertical pulse width in microseconds
`define FFC_VPULSE_US 20
// vertical pulse width in cycles (least time, rounds up)
`define FFC_VPULSE_CYC (`FFC_VPULSE_US * `FFC_CLK_MHZ)
// cycles per horizontal half period: 20 MHz / (2+2+1) = 4 MHz pixel rate, under 10 MHz
`define FFC_HHALF_CYC 12'h002
// array geometry
`define FFC_COLS 12'hc1f
`define FFC_ROWS 12'hc0e
`define FFC_LEAD_DUMMY 12'h00e
`define FFC_TRAIL_DUMMY 12'h003
`define FFC_LEAD_DARK_COLS 12'h014
`define FFC_LEAD_DARK_ROWS 12'h014
`define FFC_TRAIL_DARK_ROWS 12'h009
`define FFC_EFFECTIVE 12'hc0d
`define FFC_ACTIVE 12'hbf0
`endif

/* core/ffc_readout.v */
// readout timing controller driving a full frame ccd sensor
`timescale 1ns/1ps
`default_nettype none
`include "ffc_readout_consts.vh"
module ffc_readout (
	input wire core_clk,
	input wire rst,
	input wire frameStart,
	input wire [31:0] integCycles,
	output wire busy,
	output reg verticalPhaseOne,
	output reg verticalPhaseTwo,
	output reg horizontalPhaseOne,
	output reg horizontalPhaseTwo,
	output reg chargeClearGate,
	output reg sampleStrobe,
	output reg [11:0] pixCol,
	output reg [11:0] pixRow,
	output reg dummyPix,
	output reg darkColPix,
	output reg darkRowPix,
	output reg effectivePix,
	output reg activePix,
	output reg frameDone
);
	localparam ST_IDLE = 3'd0;
	localparam ST_INTEG = 3'd1;
	localparam ST_V1 = 3'd2;
	localparam ST_V2 = 3'd3;
	localparam ST_VEND = 3'd4;
	localparam ST_HLO = 3'd5;
	localparam ST_HHI = 3'd6;
	localparam ST_RST = 3'd7;
	// walk of one frame through the states:
	// idle waits for a start request with both vertical phases low
	// integ counts the exposure down, vertical phases held still
	// v1 raises vertical phase one for the minimum pulse width
	// v2 hands over to vertical phase two for the same width
	// vend lets the row settle in the horizontal register
	// hlo and hhi form the two halves of one horizontal pixel clock
	// rst pulses the charge clear gate once the sample is taken
	// after the last column either the next row transfer starts or the frame ends
	// horizontal phase one stays high through every vertical transfer,
	// so the falling edge of phase two always meets it high
	// the pixel period is five clocks, 4 MHz at a 20 MHz clock,
	// well below the sensor's ten megahertz limit

	// sequencer state, shared down counter, and array position
	// cnt_r is wide enough to hold any integration length the caller asks for
	reg [2:0] state_r;
	reg [31:0] cnt_r;
	reg [11:0] col_r;
	reg [11:0] row_r;
	wire lastCol = (col_r == `FFC_COLS - 12'h001);
	wire lastRow = (row_r == `FFC_ROWS - 12'h001);
	// window bounds in columns: the effective window starts after the leading
	// dummies, the active window after the leading dark columns as well
	// dummies are never counted as dark columns, so the dark column flag
	// starts only where the dummies end
	wire [11:0] effLo = `FFC_LEAD_DUMMY;
	wire [11:0] actLo = `FFC_LEAD_DUMMY + `FFC_LEAD_DARK_COLS;

	assign busy = (state_r != ST_IDLE);

	// frame sequencer and pin waveforms
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 32'h0;
			col_r <= 12'h000;
			row_r <= 12'h000;
			verticalPhaseOne <= 1'b0;
			verticalPhaseTwo <= 1'b0;
			horizontalPhaseOne <= 1'b1;
			horizontalPhaseTwo <= 1'b0;
			chargeClearGate <= 1'b0;
			sampleStrobe <= 1'b0;
			frameDone <= 1'b0;
		end else begin
			sampleStrobe <= 1'b0;
			frameDone <= 1'b0;
			chargeClearGate <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					verticalPhaseOne <= 1'b0;
					verticalPhaseTwo <= 1'b0;
					horizontalPhaseOne <= 1'b1;
					horizontalPhaseTwo <= 1'b0;
					if (frameStart) begin
						state_r <= ST_INTEG;
						cnt_r <= integCycles;
						row_r <= 12'h000;
					end
				end
				ST_INTEG: begin
					verticalPhaseOne <= 1'b0;
					verticalPhaseTwo <= 1'b0;
					if (cnt_r == 32'h0) begin
						state_r <= ST_V1;
						cnt_r <= `FFC_VPULSE_CYC - 1;
						verticalPhaseOne <= 1'b1;
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				ST_V1: begin
					horizontalPhaseOne <= 1'b1;
					horizontalPhaseTwo <= 1'b0;
					if (cnt_r == 32'h0) begin
						state_r <= ST_V2;
						cnt_r <= `FFC_VPULSE_CYC - 1;
						verticalPhaseOne <= 1'b0;
						verticalPhaseTwo <= 1'b1;
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				ST_V2: begin
					if (cnt_r == 32'h0) begin
						state_r <= ST_VEND;
						cnt_r <= `FFC_VPULSE_CYC - 1;
						verticalPhaseTwo <= 1'b0; // horizontal phase one held high here
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				ST_VEND: begin
					if (cnt_r == 32'h0) begin
						state_r <= ST_HLO;
						cnt_r <= {20'h0, `FFC_HHALF_CYC} - 32'h1;
						col_r <= 12'h000;
						horizontalPhaseOne <= 1'b0;
						horizontalPhaseTwo <= 1'b1;
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				ST_HLO: begin
					if (cnt_r == 32'h0) begin
						state_r <= ST_HHI;
						cnt_r <= {20'h0, `FFC_HHALF_CYC} - 32'h1;
						horizontalPhaseOne <= 1'b1;
						horizontalPhaseTwo <= 1'b0;
						sampleStrobe <= 1'b1; // front end samples charge on the node
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				ST_HHI: begin
					if (cnt_r == 32'h0) begin
						state_r <= ST_RST;
						chargeClearGate <= 1'b1; // reset only after the sample
					end else
						cnt_r <= cnt_r - 32'h1;
				end
				ST_RST: begin
					if (lastCol) begin
						if (lastRow) begin
							state_r <= ST_IDLE;
							frameDone <= 1'b1;
						end else begin
							state_r <= ST_V1;
							row_r <= row_r + 12'h001;
							cnt_r <= `FFC_VPULSE_CYC - 1;
							verticalPhaseOne <= 1'b1;
						end
					end else begin
						state_r <= ST_HLO;
						col_r <= col_r + 12'h001;
						cnt_r <= {20'h0, `FFC_HHALF_CYC} - 32'h1;
						horizontalPhaseOne <= 1'b0;
						horizontalPhaseTwo <= 1'b1;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// position tags that go with each sample strobe
	// tags are loaded on the same edge that raises the strobe, and held
	// until the next strobe so a slow front end can latch them late
	// all flags are decoded from the counters before they advance
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pixCol <= 12'h000;
			pixRow <= 12'h000;
			dummyPix <= 1'b0;
			darkColPix <= 1'b0;
			darkRowPix <= 1'b0;
			effectivePix <= 1'b0;
			activePix <= 1'b0;
		end else if (state_r == ST_HLO && cnt_r == 32'h0) begin
			pixCol <= col_r;
			pixRow <= row_r;
			dummyPix <= (col_r < `FFC_LEAD_DUMMY) || (col_r >= `FFC_COLS - `FFC_TRAIL_DUMMY);
			darkColPix <= (col_r >= effLo) && (col_r < actLo);
			darkRowPix <= (row_r < `FFC_LEAD_DARK_ROWS) ||
				(row_r >= `FFC_ROWS - `FFC_TRAIL_DARK_ROWS);
			effectivePix <= (col_r >= effLo) && (col_r < effLo + `FFC_EFFECTIVE) &&
				(row_r < `FFC_EFFECTIVE);
			activePix <= (col_r >= actLo) && (col_r < actLo + `FFC_ACTIVE) &&
				(row_r >= `FFC_LEAD_DARK_ROWS) && (row_r < `FFC_LEAD_DARK_ROWS + `FFC_ACTIVE);
		end
	end
endmodule
`default_nettype wire

/* test/ffc_readout_props.sv */
// assertions on the readout controller's sensor clocks and pixel tags
`timescale 1ns/1ps
`default_nettype none
module ffc_readout_props (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic frameStart,
	input wire logic [31:0] integCycles,
	input wire logic busy,
	input wire logic verticalPhaseOne,
	input wire logic verticalPhaseTwo,
	input wire logic horizontalPhaseOne,
	input wire logic horizontalPhaseTwo,
	input wire logic chargeClearGate,
	input wire logic sampleStrobe,
	input wire logic [11:0] pixCol,
	input wire logic [11:0] pixRow,
	input wire logic dummyPix,
	input wire logic darkColPix,
	input wire logic darkRowPix,
	input wire logic effectivePix,
	input wire logic activePix,
	input wire logic frameDone
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// cycles each vertical phase has been high, so the width check needs no long delay
	logic [9:0] v1Len;
	logic [9:0] v2Len;
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			v1Len <= 10'h000;
			v2Len <= 10'h000;
		end else begin
			v1Len <= verticalPhaseOne ? v1Len + 10'h001 : 10'h000;
			v2Len <= verticalPhaseTwo ? v2Len + 10'h001 : 10'h000;
		end
	end
	// phase one ends after 400 cycles and hands over to phase two
	sequence v1Handover;
		v1Len == 10'h190 && verticalPhaseTwo;
	endsequence
	// phase two ends after 400 cycles with phase one still low
	sequence v2Release;
		v2Len == 10'h190 && !verticalPhaseOne;
	endsequence
	a_v1_width: assert property ($fell(verticalPhaseOne) |-> v1Handover) else $error("phase one width wrong");
	a_v2_width: assert property ($fell(verticalPhaseTwo) |-> v2Release) else $error("phase two width wrong");
	a_integ_quiet: assert property ($rose(busy) && integCycles > 32'h7 |-> (!verticalPhaseOne && !verticalPhaseTwo) [*8]) else $error("vertical moved in integration");
	a_h_compl: assert property (horizontalPhaseOne != horizontalPhaseTwo) else $error("horizontal phases not complementary");
	a_v2_fall: assert property ($fell(verticalPhaseTwo) |-> horizontalPhaseOne && $past(horizontalPhaseOne)) else $error("phase two fell with phase one low");
	a_gate_after: assert property (sampleStrobe |-> horizontalPhaseOne && !chargeClearGate ##2 chargeClearGate) else $error("gate not after sample");
	a_pix_rate: assert property (sampleStrobe |=> !sampleStrobe [*4]) else $error("pixel rate too high");
	a_pix_tags: assert property (sampleStrobe |-> dummyPix == (pixCol < 12'h00e || pixCol > 12'hc1b) && darkColPix == (pixCol > 12'h00d && pixCol < 12'h022) && darkRowPix == (pixRow < 12'h014 || pixRow > 12'hc04)) else $error("dark or dummy tag wrong");
	a_win_tags: assert property (sampleStrobe |-> activePix == (pixCol > 12'h021 && pixCol < 12'hc12 && pixRow > 12'h013 && pixRow < 12'hc04) && effectivePix == (pixCol > 12'h00d && pixCol < 12'hc1b && pixRow < 12'hc0d)) else $error("window tag wrong");
endmodule
bind ffc_readout ffc_readout_props ffc_readout_props_i (.*);
`default_nettype wire

/* test/ffc_sensor_model.sv */
// behavioural sensor: counts rows loaded and pixels shifted out
`timescale 1ns/1ps
`default_nettype none
module ffc_sensor_model (
	input wire logic rst,
	input wire logic verticalPhaseTwo,
	input wire logic horizontalPhaseOne,
	output logic [11:0] rowCnt,
	output logic [11:0] colCnt
);
	logic [11:0] pulses = 12'h000;
	logic [11:0] base = 12'h000;
	initial rowCnt = 12'hfff;
	// a row lands as phase two falls, only with phase one high
	always @(negedge verticalPhaseTwo) if (horizontalPhaseOne && !rst) begin
		rowCnt <= rowCnt + 12'h001;
		base <= pulses;
	end
	// each phase one rise moves one pixel onto the sense node
	always @(posedge horizontalPhaseOne) pulses <= pulses + 12'h001;
	assign colCnt = pulses - base - 12'h001;
endmodule
`default_nettype wire

/* test/testbench.sv */
// testbench for the full frame readout controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk = 0, rst = 1, frameStart = 0;
	logic [31:0] integCycles = 32'h0000000a;
	wire busy, verticalPhaseOne, verticalPhaseTwo, horizontalPhaseOne, horizontalPhaseTwo, chargeClearGate;
	wire sampleStrobe, dummyPix, darkColPix, darkRowPix, effectivePix, activePix, frameDone;
	wire [11:0] pixCol, pixRow, mCol, mRow;
	int n_mismatch = 0, n_tests = 0, k, j;
	always #25 core_clk = ~core_clk;
	ffc_readout ffc_readout_i (.*);
	ffc_sensor_model ffc_sensor_model_i (.rst(rst), .verticalPhaseTwo(verticalPhaseTwo),
		.horizontalPhaseOne(horizontalPhaseOne), .rowCnt(mRow), .colCnt(mCol));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task results;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// start a frame and time the integration phase
	task t_integ;
		@(posedge core_clk) frameStart <= 1;
		@(posedge core_clk) frameStart <= 0;
		k = 0;
		do begin @(negedge core_clk); k++; end while (busy !== 1 && k < 5);
		k = 0;
		do begin @(negedge core_clk); k++; end while (verticalPhaseOne !== 1 && k < 100);
		chk(k, 11);
	endtask
	// shift out the first row, then see the second row begin
	task t_row;
		k = 0;
		j = 0;
		do begin
			@(negedge core_clk);
			j++;
			if (sampleStrobe === 1) begin
				chk(pixCol, mCol);
				chk({dummyPix, darkColPix, darkRowPix, effectivePix, activePix}, {k < 14 || k > 3099, k > 13 && k < 34, 1'b1, k > 13 && k < 3099, 1'b0});
				k++;
			end
		end while ((verticalPhaseOne !== 1 || k == 0) && j < 30000);
		chk(k, 3103);
		do @(negedge core_clk); while (sampleStrobe !== 1 && j++ < 32000);
		chk({pixRow, pixCol}, {mRow, 12'h000});
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 0;
		@(negedge core_clk);
		chk({busy, verticalPhaseOne, verticalPhaseTwo, horizontalPhaseOne, chargeClearGate}, 32'h2);
		t_integ;
		t_row;
		results;
	end
	// cut a hang short
	initial begin
		#2500000;
		n_mismatch++;
		results;
	end
endmodule
`default_nettype wire
